// ==== lmi2c_irq.sv ====
// lmi2c_irq: sticky interrupt flags, enables and timed self-release.
// assumes event inputs are one-cycle pulses on sys_clk.
`timescale 1ns/100ps
module lmi2c_irq import lmi2c_pkg::*; #(
   parameter int unsigned CLEAR_CYC = 320000
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // events: breath three..one, short, open
   input wire logic [4:0] evt,
   // register side
   lmi2c_irq_if.irq ifc,
   // pin
   output logic irq_out_n
);
   logic [4:0] flags_q;
   logic [4:0] enable;
   logic active;
   logic [31:0] low_cnt_q;
   logic expire;

   if (CLEAR_CYC < 1) begin : g_chk
      $error("lmi2c_irq: CLEAR_CYC must be at least 1");
   end

   assign enable = {{3{ifc.mask[MASK_BREATH]}}, ifc.mask[MASK_SHORT], ifc.mask[MASK_OPEN]};
   assign active = |(flags_q & enable);
   // released only after the pin has been low strictly longer than the limit
   assign expire = ifc.mask[MASK_SELF_CLEAR] && !irq_out_n && (low_cnt_q >= CLEAR_CYC);
   assign ifc.flags = flags_q;

   // sticky flags; an event in the clearing cycle survives
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         flags_q <= IRQ_FLAGS_RESET;
      end else if (ifc.status_rd || expire) begin
         flags_q <= evt;
      end else begin
         flags_q <= flags_q | evt;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         low_cnt_q <= '0;
      end else if (irq_out_n || expire) begin
         low_cnt_q <= '0;
      end else if (low_cnt_q < CLEAR_CYC) begin
         low_cnt_q <= low_cnt_q + 32'h1;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_out_n <= 1'b1;
      end else begin
         irq_out_n <= !(active && !expire);
      end
   end
endmodule

// ==== lmi2c_irq_if.sv ====
// lmi2c_irq_if: carries mask, flags and read-clear between port and irq logic.
// assumes both ends sit on sys_clk.
`timescale 1ns/100ps
interface lmi2c_irq_if;
   logic [3:0] mask;
   logic [4:0] flags;
   logic status_rd;
   modport port (output mask, output status_rd, input flags);
   modport irq (input mask, input status_rd, output flags);
endinterface

// ==== lmi2c_master.sv ====
// lmi2c_master: behavioural two-wire bus master, 8 sys_clk per bit.
// assumes the bench resolves sda from sda_low and the port's enable.
`timescale 1ns/100ps
module lmi2c_master (
   // clock
   input wire logic sys_clk,
   // bus
   input wire logic sda,
   output logic scl = 1'b1,
   output logic sda_low = 1'b0
);
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
   endtask
   // scl stays high between frames, sda released
   task automatic start();
      sda_low <= 1'b1;
      tick(3);
      scl <= 1'b0;
      tick(2);
   endtask
   task automatic rstart();
      sda_low <= 1'b0;
      tick(3);
      scl <= 1'b1;
      tick(3);
      start();
   endtask
   task automatic stop();
      sda_low <= 1'b1;
      tick(3);
      scl <= 1'b1;
      tick(3);
      sda_low <= 1'b0;
      tick(8);
   endtask
   // data set in low phase, sampled at end of high phase
   task automatic bit_io(input logic b, output logic s);
      sda_low <= !b;
      tick(3);
      scl <= 1'b1;
      tick(3);
      s = sda;
      scl <= 1'b0;
      tick(2);
   endtask
   task automatic xfer(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx,
                       output logic ack);
      for (int i = 7; i >= 0; i--) begin
         bit_io(tx[i], rx[i]);
      end
      bit_io(ack_in, ack);
   endtask
endmodule

// ==== lmi2c_pkg.sv ====
// lmi2c_pkg: constants shared by the led matrix two-wire register port.
// assumes a single 40 MHz system clock domain.
package lmi2c_pkg;
   // two-wire addressing
   localparam logic [2:0] ADDR_FIXED = 3'h5;
   localparam logic [7:0] UNLOCK_VALUE = 8'hc5;
   // register offsets
   localparam logic [7:0] REG_IRQ_MASK = 8'hf0;
   localparam logic [7:0] REG_IRQ_FLAGS = 8'hf1;
   localparam logic [7:0] REG_PAGE_SEL = 8'hfd;
   localparam logic [7:0] REG_UNLOCK = 8'hfe;
   // readable paged windows
   localparam logic [7:0] OPEN_SHORT_FIRST = 8'h18;
   localparam logic [7:0] OPEN_SHORT_LAST = 8'h45;
   localparam logic [7:0] FUNC_RESET_REG = 8'h11;
   // page codes
   localparam logic [7:0] PAGE_LED_CONTROL = 8'h00;
   localparam logic [7:0] PAGE_FUNCTION = 8'h03;
   // reset values
   localparam logic [7:0] PAGE_SEL_RESET = 8'h00;
   localparam logic [7:0] UNLOCK_RESET = 8'h00;
   localparam logic [3:0] IRQ_MASK_RESET = 4'h0;
   localparam logic [4:0] IRQ_FLAGS_RESET = 5'h00;
   // irq mask field positions
   localparam int MASK_SELF_CLEAR = 3;
   localparam int MASK_BREATH = 2;
   localparam int MASK_SHORT = 1;
   localparam int MASK_OPEN = 0;
   // timing
   localparam longint CLK_HZ = 40000000;
   localparam longint SELF_CLEAR_MS = 8;
   localparam longint SELF_CLEAR_CYC = SELF_CLEAR_MS * CLK_HZ / 1000;
   typedef enum logic [3:0] {
      ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_REG, ST_REG_ACK,
      ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_MASTER_ACK, ST_SKIP
   } lmi2c_state_t;
endpackage

// ==== lmi2c_port.sv ====
// lmi2c_port: two-wire slave register port of a matrix led driver.
// assumes scl, sda and straps come from outside sys_clk; page store is external.
// Overview of operation
// - answer the 7-bit address whose top three bits are 101
// - direction bit 0 means write, 1 means read
// - strap pins give address bits 1:0 (low) and 3:2 (high)
// - sda falling while scl high is start; begin address compare
// - sda rising while scl high is stop; ends the transfer
// - sda sampled while scl high, bytes msb first
// - on matching address, hold sda low through the ninth clock
// - first byte after write address is the register pointer, acknowledged
// - acknowledge every received data byte on its ninth clock
// - pointer increments by one during each data acknowledge
// - readable: unlock key, flags, page zero open/short, page three reset
// - read: write pointer, repeated start, read address, device returns data
// - page select values 00 to 03 pick pages zero to three
// - paged writes land in the currently selected page
// - after reset page select is locked and selects page zero
// - key c5 allows one page select write, then key returns to 00
// - mask holds four enables at zero, bits 7:4 unused
// - without self-clear an interrupt stays asserted
// - with self-clear, release irq after more than 8 ms low
// - flags: breath three..one in 4:2, short bit 1, open bit 0
`timescale 1ns/100ps
module lmi2c_port import lmi2c_pkg::*; #(
   parameter int unsigned SELF_CLEAR_CYCLES = 32'(SELF_CLEAR_CYC)
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // two-wire bus pins
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   // address straps, coded 00 gnd, 01 scl, 10 sda, 11 supply
   input wire logic [1:0] addr_strap_low,
   input wire logic [1:0] addr_strap_high,
   // paged register write port
   output logic page_wr_stb,
   output logic [7:0] page_wr_page,
   output logic [7:0] page_wr_addr,
   output logic [7:0] page_wr_data,
   // paged register read port
   output logic [7:0] page_rd_page,
   output logic [7:0] page_rd_addr,
   input wire logic [7:0] page_rd_data,
   // interrupt events and pin
   input wire logic [4:0] irq_events,
   output logic irq_out_n
);
   lmi2c_irq_if irq_bus ();

   logic [1:0] line_s;
   logic [3:0] strap_s;
   logic scl_prev_q;
   logic sda_prev_q;
   logic scl_rise;
   logic scl_fall;
   logic start_seen;
   logic stop_seen;
   lmi2c_state_t state_q;
   logic [3:0] cnt_q;
   logic [7:0] shift_q;
   logic [7:0] tx_q;
   logic [7:0] ptr_q;
   logic rw_q;
   logic master_ack_q;
   logic [7:0] page_q;
   logic [7:0] key_q;
   logic [3:0] mask_q;
   logic addr_match;
   logic wr_fire;
   logic [7:0] rd_value;
   logic rd_load;

   // pins cross into sys_clk before anything looks at them
   lmi2c_sync #(.WIDTH(2)) u_line_sync (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .d({scl_in, sda_in}),
      .q(line_s)
   );

   lmi2c_sync #(.WIDTH(4)) u_strap_sync (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .d({addr_strap_high, addr_strap_low}),
      .q(strap_s)
   );

   lmi2c_irq #(.CLEAR_CYC(SELF_CLEAR_CYCLES)) u_irq (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .evt(irq_events),
      .ifc(irq_bus.irq),
      .irq_out_n(irq_out_n)
   );

   // released sda idles high at reset, so no false start
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         scl_prev_q <= 1'b1;
         sda_prev_q <= 1'b1;
      end else begin
         scl_prev_q <= line_s[1];
         sda_prev_q <= line_s[0];
      end
   end

   assign scl_rise = line_s[1] && !scl_prev_q;
   assign scl_fall = !line_s[1] && scl_prev_q;
   assign start_seen = line_s[1] && scl_prev_q && sda_prev_q && !line_s[0];
   assign stop_seen = line_s[1] && scl_prev_q && !sda_prev_q && line_s[0];

   // shift holds 7 address bits then direction bit
   assign addr_match = shift_q[7:1] == {ADDR_FIXED, strap_s[3:2], strap_s[1:0]};

   // write commits on the falling edge ending the eighth data bit
   assign wr_fire = scl_fall && (state_q == ST_WDATA) && (cnt_q == 4'h8);

   // value for a read from the current pointer
   always_comb begin
      rd_value = 8'h00;
      if (ptr_q == REG_UNLOCK) begin
         rd_value = key_q;
      end else if (ptr_q == REG_IRQ_FLAGS) begin
         rd_value = {3'h0, irq_bus.flags};
      end else if (page_q == PAGE_LED_CONTROL && ptr_q >= OPEN_SHORT_FIRST
                   && ptr_q <= OPEN_SHORT_LAST) begin
         rd_value = page_rd_data;
      end else if ((page_q == PAGE_LED_CONTROL || page_q == PAGE_FUNCTION)
                   && ptr_q == FUNC_RESET_REG) begin
         // page three reset register, reached with page zero selected
         rd_value = page_rd_data;
      end
   end

   // a byte is fetched for transmit on these falling edges
   assign rd_load = scl_fall && ((state_q == ST_ADDR_ACK && rw_q)
                    || (state_q == ST_MASTER_ACK && master_ack_q));

   // bus state machine
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= ST_IDLE;
      end else if (start_seen) begin
         state_q <= ST_ADDR;
      end else if (stop_seen) begin
         state_q <= ST_IDLE;
      end else if (scl_fall) begin
         case (state_q)
            ST_ADDR: begin
               if (cnt_q == 4'h8) begin
                  state_q <= addr_match ? ST_ADDR_ACK : ST_SKIP;
               end
            end
            ST_ADDR_ACK: begin
               state_q <= rw_q ? ST_RDATA : ST_REG;
            end
            ST_REG: begin
               if (cnt_q == 4'h8) begin
                  state_q <= ST_REG_ACK;
               end
            end
            ST_REG_ACK: begin
               state_q <= ST_WDATA;
            end
            ST_WDATA: begin
               if (cnt_q == 4'h8) begin
                  state_q <= ST_WDATA_ACK;
               end
            end
            ST_WDATA_ACK: begin
               state_q <= ST_WDATA;
            end
            ST_RDATA: begin
               if (cnt_q == 4'h8) begin
                  state_q <= ST_MASTER_ACK;
               end
            end
            ST_MASTER_ACK: begin
               // a missing master acknowledge ends the read
               state_q <= master_ack_q ? ST_RDATA : ST_SKIP;
            end
            default: begin
               state_q <= state_q;
            end
         endcase
      end
   end

   // bit counter: received bits, or bits already put on sda when sending
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= 4'h0;
      end else if (start_seen) begin
         cnt_q <= 4'h0;
      end else if (scl_rise && cnt_q < 4'h8 && (state_q == ST_ADDR
                   || state_q == ST_REG || state_q == ST_WDATA)) begin
         cnt_q <= cnt_q + 4'h1;
      end else if (scl_fall) begin
         if (rd_load) begin
            cnt_q <= 4'h1;
         end else if (state_q == ST_RDATA && cnt_q < 4'h8) begin
            cnt_q <= cnt_q + 4'h1;
         end else if (state_q == ST_ADDR_ACK || state_q == ST_REG_ACK
                      || state_q == ST_WDATA_ACK) begin
            cnt_q <= 4'h0;
         end
      end
   end

   // receive shifter, msb first
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         shift_q <= 8'h00;
      end else if (scl_rise && cnt_q < 4'h8 && (state_q == ST_ADDR
                   || state_q == ST_REG || state_q == ST_WDATA)) begin
         shift_q <= {shift_q[6:0], line_s[0]};
      end
   end

   // direction bit and master acknowledge
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rw_q <= 1'b0;
         master_ack_q <= 1'b0;
      end else begin
         if (scl_fall && state_q == ST_ADDR && cnt_q == 4'h8) begin
            rw_q <= shift_q[0];
         end
         if (scl_rise && state_q == ST_MASTER_ACK) begin
            master_ack_q <= !line_s[0];
         end
      end
   end

   // register pointer; kept across a repeated start for the read phase
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         ptr_q <= 8'h00;
      end else if (scl_fall && state_q == ST_REG && cnt_q == 4'h8) begin
         ptr_q <= shift_q;
      end else if (wr_fire) begin
         ptr_q <= ptr_q + 8'h01;
      end else if (scl_rise && state_q == ST_MASTER_ACK && !line_s[0]) begin
         // advanced well before the next fetch so the page store can answer
         ptr_q <= ptr_q + 8'h01;
      end
   end

   // transmit byte
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_q <= 8'h00;
      end else if (rd_load) begin
         tx_q <= rd_value;
      end
   end

   // reading the flags register clears all flags held one cycle after the fetch, including one raised at the fetch edge
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_bus.status_rd <= 1'b0;
      end else begin
         irq_bus.status_rd <= rd_load && ptr_q == REG_IRQ_FLAGS;
      end
   end

   // sda driver; open drain, so only ever pulls low
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         sda_oe <= 1'b0;
      end else if (start_seen || stop_seen) begin
         sda_oe <= 1'b0;
      end else if (scl_fall) begin
         case (state_q)
            ST_ADDR: begin
               sda_oe <= cnt_q == 4'h8 && addr_match;
            end
            ST_REG, ST_WDATA: begin
               sda_oe <= cnt_q == 4'h8;
            end
            ST_ADDR_ACK: begin
               sda_oe <= rw_q && !rd_value[7];
            end
            ST_RDATA: begin
               sda_oe <= cnt_q < 4'h8 && !tx_q[3'(7 - cnt_q)];
            end
            ST_MASTER_ACK: begin
               sda_oe <= master_ack_q && !rd_value[7];
            end
            default: begin
               sda_oe <= 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         sda_out <= 1'b0;
      end else begin
         sda_out <= 1'b0;
      end
   end

   // page select and its one-shot unlock key
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         page_q <= PAGE_SEL_RESET;
         key_q <= UNLOCK_RESET;
      end else if (wr_fire) begin
         if (ptr_q == REG_UNLOCK) begin
            key_q <= shift_q;
         end else if (ptr_q == REG_PAGE_SEL && key_q == UNLOCK_VALUE) begin
            page_q <= shift_q;
            key_q <= UNLOCK_RESET;
         end
      end
   end

   // interrupt mask; upper bits are not stored
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         mask_q <= IRQ_MASK_RESET;
      end else if (wr_fire && ptr_q == REG_IRQ_MASK) begin
         mask_q <= shift_q[3:0];
      end
   end

   assign irq_bus.mask = mask_q;

   // paged writes go out with the page current at that moment
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         page_wr_stb <= 1'b0;
         page_wr_page <= 8'h00;
         page_wr_addr <= 8'h00;
         page_wr_data <= 8'h00;
      end else begin
         page_wr_stb <= wr_fire && ptr_q != REG_IRQ_MASK && ptr_q != REG_IRQ_FLAGS
                        && ptr_q != REG_PAGE_SEL && ptr_q != REG_UNLOCK;
         if (wr_fire) begin
            page_wr_page <= page_q;
            page_wr_addr <= ptr_q;
            page_wr_data <= shift_q;
         end
      end
   end

   // read address follows the pointer one cycle later
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         page_rd_page <= 8'h00;
         page_rd_addr <= 8'h00;
      end else begin
         if (ptr_q == FUNC_RESET_REG) begin
            page_rd_page <= PAGE_FUNCTION;
         end else begin
            page_rd_page <= page_q;
         end
         page_rd_addr <= ptr_q;
      end
   end
endmodule

// ==== lmi2c_port_assertions.sv ====
// lmi2c_port_assertions: timing checks on the two-wire register port pins.
// assumes one sys_clk domain; bound to lmi2c_port below.
`timescale 1ns/100ps
module lmi2c_port_assertions #(
   parameter int unsigned SELF_CLEAR_CYCLES = 320000
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // bus pins
   input wire logic scl_in,
   input wire logic sda_out,
   input wire logic sda_oe,
   // paged write port
   input wire logic page_wr_stb,
   input wire logic [7:0] page_wr_addr,
   // interrupt
   input wire logic [4:0] irq_events,
   input wire logic irq_out_n
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   logic scl_q;
   logic [3:0] fall_cnt_q;
   logic [4:0] quiet_cnt_q;
   logic [31:0] low_cnt_q;
   // saturating counters; ages of the last scl fall and scl change
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         scl_q <= 1'b1;
         fall_cnt_q <= 4'hf;
         quiet_cnt_q <= 5'h00;
      end else begin
         scl_q <= scl_in;
         fall_cnt_q <= (scl_q && !scl_in) ? 4'h1 : fall_cnt_q + 4'(fall_cnt_q != 4'hf);
         quiet_cnt_q <= (scl_q != scl_in) ? 5'h01 : quiet_cnt_q + 5'(quiet_cnt_q != 5'h1f);
      end
   end
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         low_cnt_q <= 32'h0;
      end else begin
         low_cnt_q <= irq_out_n ? 32'h0 : low_cnt_q + 32'h1;
      end
   end
   open_drain_a: assert property (sda_out == 1'b0)
      else $error("sda driven high");
   ack_launch_a: assert property ($rose(sda_oe) |-> fall_cnt_q >= 4'h2 && fall_cnt_q <= 4'h5)
      else $error("sda pulled outside the low phase window");
   hold_high_a: assert property (scl_in [*6] |-> $stable(sda_oe))
      else $error("sda changed while scl high");
   idle_release_a: assert property (quiet_cnt_q == 5'h1f && scl_in |-> !sda_oe)
      else $error("sda held on idle bus");
   stb_pulse_a: assert property (page_wr_stb |=> !page_wr_stb)
      else $error("write strobe longer than one clock");
   stb_in_ack_a: assert property (page_wr_stb |-> ##[0:2] sda_oe)
      else $error("paged write without acknowledge");
   irq_rise_a: assert property ($rose(irq_out_n) |->
      low_cnt_q >= SELF_CLEAR_CYCLES - 1 || quiet_cnt_q < 5'h10)
      else $error("interrupt released without cause");
   irq_fall_a: assert property ($fell(irq_out_n) |-> $past(irq_events) != 5'h00 ||
      $past(irq_events, 2) != 5'h00 || quiet_cnt_q < 5'h10)
      else $error("interrupt asserted without event");
   reset_state_a: assert property ($rose(rst_n) |->
      irq_out_n && !sda_oe && !page_wr_stb && page_wr_addr == 8'h00)
      else $error("outputs not at reset values");
endmodule
bind lmi2c_port lmi2c_port_assertions #(.SELF_CLEAR_CYCLES(SELF_CLEAR_CYCLES)) chk_u (
   .sys_clk(sys_clk),
   .rst_n(rst_n),
   .scl_in(scl_in),
   .sda_out(sda_out),
   .sda_oe(sda_oe),
   .page_wr_stb(page_wr_stb),
   .page_wr_addr(page_wr_addr),
   .irq_events(irq_events),
   .irq_out_n(irq_out_n)
);

// ==== lmi2c_port_tb.sv ====
// lmi2c_port_tb: self-checking bench for the two-wire register port.
// assumes the port answers the strapped address 1010110.
`timescale 1ns/100ps
module lmi2c_port_tb;
   import lmi2c_pkg::*;
   localparam int unsigned CLR = 50;
   localparam logic [7:0] DEV_W = 8'hac;
   localparam logic [7:0] DEV_R = 8'had;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [1:0] strap_lo = 2'h2;
   logic [1:0] strap_hi = 2'h1;
   logic [4:0] irq_events = 5'h00;
   logic scl, sda, m_low, sda_out, sda_oe, page_wr_stb, irq_out_n;
   logic [7:0] page_wr_page, page_wr_addr, page_wr_data, page_rd_page, page_rd_addr;
   logic [23:0] pw_q[$];
   int failures = 0;
   int n_compared = 0;
   always #12.5 sys_clk = !sys_clk;
   assign sda = !(m_low || sda_oe);
   // page store model; contents are a fixed function of page and address
   wire [7:0] page_rd_data = page_rd_addr ^ page_rd_page ^ 8'h5a;
   always @(posedge sys_clk) begin
      if (page_wr_stb === 1'b1) pw_q.push_back({page_wr_page, page_wr_addr, page_wr_data});
   end
   lmi2c_master mst_u (.sys_clk(sys_clk), .sda(sda), .scl(scl), .sda_low(m_low));
   lmi2c_port #(.SELF_CLEAR_CYCLES(CLR)) dut_u (
      .sys_clk(sys_clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda),
      .sda_out(sda_out), .sda_oe(sda_oe),
      .addr_strap_low(strap_lo), .addr_strap_high(strap_hi),
      .page_wr_stb(page_wr_stb), .page_wr_page(page_wr_page),
      .page_wr_addr(page_wr_addr), .page_wr_data(page_wr_data),
      .page_rd_page(page_rd_page), .page_rd_addr(page_rd_addr),
      .page_rd_data(page_rd_data), .irq_events(irq_events), .irq_out_n(irq_out_n));
   task automatic complete_run();
      if (failures == 0 && n_compared > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
      n_compared++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value at %0t: %s got %h want %h", $time, msg, seen, exp);
      end
   endtask
   task automatic wb(input logic [7:0] b, input logic exp_ack);
      logic [7:0] rx;
      logic ak;
      mst_u.xfer(b, 1'b1, rx, ak);
      check({7'h0, ak}, {7'h0, !exp_ack}, "ack");
   endtask
   task automatic wr(input logic [7:0] r, input logic [7:0] d);
      mst_u.start();
      wb(DEV_W, 1'b1);
      wb(r, 1'b1);
      wb(d, 1'b1);
      mst_u.stop();
   endtask
   task automatic rd(input logic [7:0] r, output logic [7:0] d);
      logic ak;
      mst_u.start();
      wb(DEV_W, 1'b1);
      wb(r, 1'b1);
      mst_u.rstart();
      wb(DEV_R, 1'b1);
      mst_u.xfer(8'hff, 1'b1, d, ak);
      mst_u.stop();
   endtask
   task automatic chk_pw(input logic [23:0] exp);
      logic [23:0] got;
      got = (pw_q.size() > 0) ? pw_q.pop_front() : 24'hx;
      check(got[23:16], exp[23:16], "write page");
      check(got[15:8], exp[15:8], "write addr");
      check(got[7:0], exp[7:0], "write data");
   endtask
   task automatic sc_address();
      for (int i = 0; i < 4; i++) begin
         strap_lo <= 2'(i);
         strap_hi <= 2'(3 - i);
         repeat (4) @(posedge sys_clk);
         mst_u.start();
         wb({3'h5, 2'(3 - i), 2'(i), 1'b0}, 1'b1);
         mst_u.stop();
      end
      strap_lo <= 2'h2;
      strap_hi <= 2'h1;
      repeat (4) @(posedge sys_clk);
      mst_u.start();
      wb(8'h8c, 1'b0);
      wb(8'h00, 1'b0);
      mst_u.stop();
   endtask
   task automatic sc_lock();
      logic [7:0] d;
      rd(REG_UNLOCK, d);
      check(d, UNLOCK_RESET, "key reset");
      wr(REG_PAGE_SEL, 8'h02);
      wr(8'h07, 8'ha5);
      chk_pw({PAGE_SEL_RESET, 8'h07, 8'ha5});
      for (int p = 3; p >= 0; p--) begin
         wr(REG_UNLOCK, UNLOCK_VALUE);
         rd(REG_UNLOCK, d);
         check(d, UNLOCK_VALUE, "key set");
         wr(REG_PAGE_SEL, 8'(p));
         rd(REG_UNLOCK, d);
         check(d, 8'h00, "key spent");
         wr(8'h07, 8'(p));
         chk_pw({8'(p), 8'h07, 8'(p)});
      end
      wr(REG_PAGE_SEL, 8'h01);
      wr(8'h08, 8'h3c);
      chk_pw({8'h00, 8'h08, 8'h3c});
   endtask
   task automatic sc_burst();
      mst_u.start();
      wb(DEV_W, 1'b1);
      wb(8'h2e, 1'b1);
      for (int i = 0; i < 3; i++) begin
         wb(8'(8'h11 * (i + 1)), 1'b1);
      end
      mst_u.stop();
      for (int i = 0; i < 3; i++) begin
         chk_pw({8'h00, 8'(8'h2e + i), 8'(8'h11 * (i + 1))});
      end
   endtask
   task automatic sc_read();
      logic [7:0] d;
      logic ak;
      mst_u.start();
      wb(DEV_W, 1'b1);
      wb(8'h44, 1'b1);
      mst_u.rstart();
      wb(DEV_R, 1'b1);
      for (int i = 0; i < 3; i++) begin
         mst_u.xfer(8'hff, i == 2, d, ak);
         check(d, (i < 2) ? 8'(8'h44 + i) ^ 8'h5a : 8'h00, "burst read");
      end
      mst_u.stop();
      rd(REG_IRQ_MASK, d);
      check(d, 8'h00, "mask unreadable");
      rd(FUNC_RESET_REG, d);
      check(d, FUNC_RESET_REG ^ PAGE_FUNCTION ^ 8'h5a, "reset reg");
   endtask
   task automatic pulse(input logic [4:0] e);
      irq_events <= e;
      @(posedge sys_clk);
      irq_events <= 5'h00;
      // pin is launched on the second edge; look one edge later
      repeat (2) @(posedge sys_clk);
   endtask
   task automatic sc_irq();
      logic [7:0] d;
      int n;
      wr(REG_IRQ_MASK, 8'hf2);
      pulse(5'h01);
      check({7'h0, irq_out_n}, 8'h01, "masked open");
      pulse(5'h02);
      check({7'h0, irq_out_n}, 8'h00, "short irq");
      repeat (3 * CLR) @(posedge sys_clk);
      check({7'h0, irq_out_n}, 8'h00, "irq held");
      rd(REG_IRQ_FLAGS, d);
      check(d, 8'h03, "flags");
      check({7'h0, irq_out_n}, 8'h01, "irq cleared");
      wr(REG_IRQ_MASK, 8'h0c);
      pulse(5'h10);
      check({7'h0, irq_out_n}, 8'h00, "breath irq");
      for (n = 0; n < 4 * CLR && irq_out_n !== 1'b1; n++) begin
         @(posedge sys_clk);
      end
      check(8'(n + 3 >= CLR && n <= CLR + 2), 8'h01, "self clear time");
      rd(REG_IRQ_FLAGS, d);
      check(d, 8'h00, "flags after self clear");
   endtask
   initial begin
      repeat (100000) @(posedge sys_clk);
      failures++;
      complete_run();
   end
   initial begin
      repeat (10) @(posedge sys_clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge sys_clk);
      sc_address();
      sc_lock();
      sc_burst();
      sc_read();
      sc_irq();
      complete_run();
   end
endmodule

// ==== lmi2c_sync.sv ====
// lmi2c_sync: two flip-flop synchroniser for levels from outside sys_clk.
// assumes inputs are quasi-static or slow against sys_clk.
`timescale 1ns/100ps
module lmi2c_sync import lmi2c_pkg::*; #(
   parameter int WIDTH = 2
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // level in and out
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta_q;

   if (WIDTH < 1) begin : g_chk
      $error("lmi2c_sync: WIDTH must be at least 1");
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         // idle bus level, so edge detectors see no false edge after reset
         meta_q <= '1;
         q <= '1;
      end else begin
         meta_q <= d;
         q <= meta_q;
      end
   end
endmodule
